/* File: src/lcc_cluster.sv */
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`include "lcc_defs.svh"
module lcc_cluster (
  input  wire logic                                   I_SYS_CLK,
  input  wire logic                                   I_RSTN,
  input  wire logic                                   I_CE,
  input  wire logic [`LCC_ADDR_W-1:0]                 I_ADDR,
  input  wire logic [`LCC_DATA_W-1:0]                 I_WDATA,
  input  wire logic                                   I_WE,
  input  wire logic                                   I_RE,
  output logic      [`LCC_DATA_W-1:0]                 O_RDATA,
  input  wire lcc_pkg::lcc_ctrl_src_t                 I_CTRL_SRC,
  input  wire logic                                   I_CHIP_RSTN,
  input  wire lcc_pkg::lcc_cell_data_t [`LCC_NUM_CELLS-1:0] I_CELL_DATA,
  input  wire logic                                   I_CARRY_IN,
  input  wire logic                                   I_CASCADE_IN,
  output logic                                        O_CARRY_OUT,
  output logic                                        O_CASCADE_OUT,
  output logic      [`LCC_NUM_CELLS-1:0]              O_LOCAL_OUT,
  output logic      [`LCC_NUM_CELLS-1:0]              O_ROW_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic lut_rd(input logic [15:0] mask, input logic [3:0] idx);
    lut_rd = mask[idx];
  endfunction

  function automatic logic [3:0] reg_idx(input logic [`LCC_ADDR_W-1:0] addr);
    if (addr[1:0] != 2'h0) begin
      reg_idx = `LCC_IDX_NONE;
    end else if (addr < `LCC_OFS_CLU_CFG) begin
      reg_idx = addr[5:2];
    end else if (addr == `LCC_OFS_CLU_CFG) begin
      reg_idx = `LCC_IDX_CLU;
    end else if (addr == `LCC_OFS_STATUS) begin
      reg_idx = `LCC_IDX_STATUS;
    end else if (addr == `LCC_OFS_LINES) begin
      reg_idx = `LCC_IDX_LINES;
    end else begin
      reg_idx = `LCC_IDX_NONE;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  lcc_pkg::lcc_cell_cfg_t [`LCC_NUM_CELLS-1:0] cell_cfg_q, cell_cfg_d;
  lcc_pkg::lcc_clu_cfg_t                       clu_cfg_q, clu_cfg_d;
  logic [`LCC_DATA_W-1:0]                      rdata_d, rdata_q;
  logic [3:0]                                  wr_idx, rd_idx;
  logic [`LCC_NUM_CELLS-1:0]                   cell_q, cell_d;
  logic [`LCC_NUM_LINES-1:0]                   line;
  wire  [`LCC_NUM_CELLS:0]                     carry;
  wire  [`LCC_NUM_CELLS:0]                     cas;

  // Static setup, written by software only
  always_comb begin
    wr_idx     = reg_idx(I_ADDR);
    cell_cfg_d = cell_cfg_q;
    clu_cfg_d  = clu_cfg_q;
    if (I_WE) begin
      if (wr_idx < `LCC_IDX_CLU) begin
        cell_cfg_d[wr_idx[2:0]] = I_WDATA; // RQ25
      end else if (wr_idx == `LCC_IDX_CLU) begin
        clu_cfg_d = I_WDATA; // RQ25
      end
    end
  end

  always_comb begin
    rd_idx  = reg_idx(I_ADDR);
    rdata_d = `LCC_DATA_W'(0);
    if (I_RE) begin
      if (rd_idx < `LCC_IDX_CLU) begin
        rdata_d = cell_cfg_q[rd_idx[2:0]];
      end else if (rd_idx == `LCC_IDX_CLU) begin
        rdata_d = clu_cfg_q;
      end else if (rd_idx == `LCC_IDX_STATUS) begin
        rdata_d = {22'h00_0000, cas[`LCC_NUM_CELLS], carry[`LCC_NUM_CELLS], cell_q};
      end else if (rd_idx == `LCC_IDX_LINES) begin
        rdata_d = {28'h000_0000, line};
      end
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      cell_cfg_q <= {`LCC_NUM_CELLS{`LCC_CELL_RST}};
      clu_cfg_q  <= `LCC_CLU_RST;
      rdata_q    <= `LCC_DATA_W'(0);
    end else if (I_CE) begin
      cell_cfg_q <= cell_cfg_d;
      clu_cfg_q  <= clu_cfg_d;
      rdata_q    <= rdata_d;
    end
  end

  assign O_RDATA = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Shared control lines

  lcc_pkg::lcc_ctrl_src_t       src_s1_q, src_s2_q;
  logic                         rstn_s1_q, rstn_s2_q;
  logic [`LCC_NUM_CLKS-1:0]     clk_prev_q, clk_rise;
  logic [`LCC_NUM_LINES-1:0]    raw;
  logic                         chip_rst;

  // Line source select and inversion
  always_comb begin
    for (int l = 0; l < `LCC_NUM_LINES; l++) begin
      unique case (clu_cfg_q.src_sel[l])
        // Dedicated clock inputs reach only the clock lines
        `LCC_SRC_DED:    raw[l] = (l < `LCC_NUM_CLKS) ? src_s2_q.ded_clk[l % 2] : src_s2_q.local_sig[l]; // RQ3
        `LCC_SRC_GLOBAL: raw[l] = src_s2_q.global_sig[l]; // RQ3
        `LCC_SRC_IO:     raw[l] = src_s2_q.io_sig[l]; // RQ3
        `LCC_SRC_LOCAL:  raw[l] = src_s2_q.local_sig[l]; // RQ3
      endcase
      line[l] = raw[l] ^ clu_cfg_q.inv[l]; // RQ1
    end
    clk_rise = line[`LCC_NUM_CLKS-1:0] & ~clk_prev_q; // RQ2
    chip_rst = !rstn_s2_q;
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      src_s1_q   <= '0;
      src_s2_q   <= '0;
      rstn_s1_q  <= 1'b0;
      rstn_s2_q  <= 1'b0;
      clk_prev_q <= '0;
    end else if (I_CE) begin
      src_s1_q   <= I_CTRL_SRC;
      src_s2_q   <= src_s1_q;
      rstn_s1_q  <= I_CHIP_RSTN;
      rstn_s2_q  <= rstn_s1_q;
      clk_prev_q <= line[`LCC_NUM_CLKS-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Logic cells

  logic [`LCC_NUM_CELLS-1:0] comb_v, loc_d, row_d, clr_v, pre_v, upd_v;

  // Chain heads; a break feeds the neutral value
  assign carry[0] = clu_cfg_q.break_carry ? 1'b0 : I_CARRY_IN; // RQ11 RQ10
  assign cas[0]   = clu_cfg_q.break_casc ? ~cell_cfg_q[0].casc_or : I_CASCADE_IN; // RQ16 RQ15

  for (genvar i = 0; i < `LCC_NUM_CELLS; i++) begin : g_cell
    lcc_pkg::lcc_cell_cfg_t  c;
    lcc_pkg::lcc_cell_data_t d;
    logic cin, lut_o, sum_o, cy_o, cnt_o, ccy_o, updn, ldmux, base, cout, comb, ffsrc, nxt, ce, clr, pre, edge_s;

    assign c = cell_cfg_q[i];
    assign d = I_CELL_DATA[i];
    assign cin = carry[i];

    always_comb begin
      // Normal: four-input table, input three may be the carry
      lut_o = lut_rd(c.lut_mask, {d.cell_data_in_four,
                                  c.carry_as_d3 ? cin : d.cell_data_in_three,
                                  d.cell_data_in_two, d.cell_data_in_one}); // RQ4 RQ9
      // Arithmetic: low half sums, high half carries
      sum_o = lut_rd(c.lut_mask, {1'b0, cin, d.cell_data_in_three, d.cell_data_in_two}); // RQ21 RQ9
      cy_o  = lut_rd(c.lut_mask, {1'b1, cin, d.cell_data_in_three, d.cell_data_in_two}); // RQ21 RQ12
      // Counters: feedback, carry and up/down into split table
      updn  = (c.mode == lcc_pkg::MODE_CLRCNT) ? 1'b0 : d.cell_data_in_three;
      cnt_o = lut_rd(c.lut_mask, {1'b0, cin, cell_q[i], updn}); // RQ18
      ccy_o = lut_rd(c.lut_mask, {1'b1, cin, cell_q[i], updn});
      ldmux = d.cell_data_in_four ? d.cell_data_in_two : cnt_o; // RQ22
      if (c.mode == lcc_pkg::MODE_CLRCNT) begin
        ldmux = ldmux & ~d.cell_data_in_three; // RQ23
      end
      unique case (c.mode) // RQ17
        lcc_pkg::MODE_NORMAL: begin
          base = lut_o;
          cout = cin;
        end
        lcc_pkg::MODE_ARITH: begin
          base = sum_o;
          cout = cy_o;
        end
        lcc_pkg::MODE_UPDN,
        lcc_pkg::MODE_CLRCNT: begin
          base = cnt_o;
          cout = ccy_o;
        end
      endcase
      // Cascade: AND, or OR as inverted AND of inverted terms
      if (!c.casc_en) begin
        comb = base;
      end else if (c.casc_or) begin
        comb = ~(~base & ~cas[i]); // RQ13 RQ14
      end else begin
        comb = base & cas[i]; // RQ13 RQ14
      end
      // Register input: packed data four, counter mux or table
      if (c.mode == lcc_pkg::MODE_UPDN || c.mode == lcc_pkg::MODE_CLRCNT) begin
        ffsrc = ldmux;
      end else if (c.pack_d4) begin
        ffsrc = d.cell_data_in_four;
      end else begin
        ffsrc = comb;
      end
      // Counters always load as D; three is K or R otherwise
      if (c.mode == lcc_pkg::MODE_UPDN || c.mode == lcc_pkg::MODE_CLRCNT) begin
        nxt = ffsrc;
      end else begin
        unique case (c.ff_type) // RQ5
          lcc_pkg::FF_D:  nxt = ffsrc;
          lcc_pkg::FF_T:  nxt = cell_q[i] ^ ffsrc;
          lcc_pkg::FF_JK: nxt = (ffsrc & ~cell_q[i]) | (~d.cell_data_in_three & cell_q[i]);
          lcc_pkg::FF_SR: nxt = ffsrc | (cell_q[i] & ~d.cell_data_in_three);
        endcase
      end
      ce     = c.ce_from_d1 ? d.cell_data_in_one : 1'b1; // RQ20
      edge_s = clk_rise[c.clk_sel]; // RQ19
      clr    = c.clr_en & line[2 + int'(c.clr_sel)]; // RQ19
      pre    = c.pre_en & line[3 - int'(c.clr_sel)]; // RQ19
    end

    assign carry[i+1] = cout; // RQ8 RQ9
    assign cas[i+1]   = comb; // RQ8
    assign comb_v[i]  = comb;
    assign clr_v[i]   = clr;
    assign pre_v[i]   = pre;
    assign upd_v[i]   = edge_s & ce;

    // Reset wins, then clear, preset, clocked update
    assign cell_d[i] = chip_rst ? 1'b0 : // RQ24
                       clr      ? 1'b0 :
                       pre      ? 1'b1 :
                       (edge_s & ce) ? nxt : cell_q[i]; // RQ26 RQ5
    assign loc_d[i] = c.loc_sel_reg ? cell_q[i] : comb; // RQ6 RQ7
    assign row_d[i] = c.row_sel_reg ? cell_q[i] : comb; // RQ6 RQ7
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cell registers and output stage

  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      cell_q        <= '0;
      O_LOCAL_OUT   <= '0;
      O_ROW_OUT     <= '0;
      O_CARRY_OUT   <= 1'b0;
      O_CASCADE_OUT <= 1'b0;
    end else if (I_CE) begin
      cell_q        <= cell_d;
      O_LOCAL_OUT   <= loc_d;
      O_ROW_OUT     <= row_d;
      O_CARRY_OUT   <= carry[`LCC_NUM_CELLS]; // RQ8 RQ10
      O_CASCADE_OUT <= cas[`LCC_NUM_CELLS]; // RQ8 RQ15
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic                      all_adder;
  logic [`LCC_NUM_CELLS-1:0] opa, opb;

  always_comb begin
    all_adder = !clu_cfg_q.break_carry;
    for (int k = 0; k < `LCC_NUM_CELLS; k++) begin
      opa[k] = I_CELL_DATA[k].cell_data_in_two;
      opb[k] = I_CELL_DATA[k].cell_data_in_three;
      all_adder = all_adder && cell_cfg_q[k].mode == lcc_pkg::MODE_ARITH &&
                  cell_cfg_q[k].lut_mask == `LCC_ADDER_MASK && !cell_cfg_q[k].casc_en;
    end
  end

  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RSTN);

  a_hold_no_edge: assert property (I_CE && !chip_rst && clr_v == '0 && pre_v == '0 && upd_v == '0 // RQ26
    |=> $stable(cell_q)) else $error("Cell register changed without clock edge");

  a_chip_reset_wins: assert property (I_CE && chip_rst |=> cell_q == '0) // RQ24
    else $error("Chip reset did not clear all cells");

  a_clear_line: assert property (I_CE && !chip_rst && clr_v != '0 // RQ19
    |=> (cell_q & $past(clr_v)) == '0) else $error("Cleared cell not low");

  a_preset_line: assert property (I_CE && !chip_rst && pre_v != '0 // RQ19
    |=> (cell_q & $past(pre_v & ~clr_v)) == $past(pre_v & ~clr_v)) else $error("Preset cell not high");

  a_bypass_local: assert property (I_CE && !cell_cfg_q[0].loc_sel_reg // RQ6
    |=> O_LOCAL_OUT[0] == $past(comb_v[0])) else $error("Local output not table result");

  a_row_register: assert property (I_CE && cell_cfg_q[0].row_sel_reg // RQ7
    |=> O_ROW_OUT[0] == $past(cell_q[0])) else $error("Row output not register");

  a_adder_chain: assert property (all_adder // RQ12
    |-> {carry[`LCC_NUM_CELLS], comb_v} == 9'(opa) + 9'(opb) + 9'(carry[0])) else $error("Adder sum wrong");

  a_cascade_and: assert property (cell_cfg_q[1].casc_en && !cell_cfg_q[1].casc_or && !cas[1] // RQ13
    |-> !cas[2]) else $error("AND cascade passed a low term");

  a_cascade_or: assert property (cell_cfg_q[1].casc_en && cell_cfg_q[1].casc_or && cas[1] // RQ13
    |-> cas[2]) else $error("OR cascade dropped a high term");

  a_sync_clear: assert property (I_CE && !chip_rst && clr_v[0] == 1'b0 && pre_v[0] == 1'b0 && upd_v[0] // RQ23
    && cell_cfg_q[0].mode == lcc_pkg::MODE_CLRCNT && I_CELL_DATA[0].cell_data_in_three
    |=> !cell_q[0]) else $error("Synchronous clear ignored");

  a_carry_out_reg: assert property (I_CE ##1 I_CE |-> O_CARRY_OUT == $past(carry[`LCC_NUM_CELLS])) // RQ8
    else $error("Carry out not forwarded");

  c_adder_carry: cover property (all_adder && carry[`LCC_NUM_CELLS]);
  c_cascade_wide: cover property (cell_cfg_q[7].casc_en && cas[`LCC_NUM_CELLS]);
  c_counter_tick: cover property (cell_cfg_q[0].mode == lcc_pkg::MODE_UPDN && upd_v[0] ##1 cell_q[0]);
  c_chip_reset: cover property (chip_rst ##1 !chip_rst);

endmodule // lcc_cluster

/* File: src/lcc_defs.svh */
`ifndef LCC_DEFS_SVH
`define LCC_DEFS_SVH
// Operation
// [RQ1] Cluster has four shared control lines with inversion, usable by all eight cells.
// [RQ2] Lines zero and one act as clocks, lines two and three as clear/preset.
// [RQ3] Clock lines take dedicated, global, I/O or local sources; clear lines not dedicated.
// [RQ4] Every cell has a four-input lookup table for any function of four inputs.
// [RQ5] Cell register works as D, T, JK or SR flip-flop with clock enable.
// [RQ6] Combinational use bypasses the register; table result drives the output.
// [RQ7] Local and row outputs each choose register or table result independently.
// [RQ8] Carry and cascade chains run through all cells and on to row neighbours.
// [RQ9] Incoming carry feeds the cell's table and the next carry stage.
// [RQ10] Carry past eight cells continues in the cluster two places along, parity kept.
// [RQ11] Carry chain stops at the mid-row memory column; fresh chain starts beyond.
// [RQ12] An n-bit adder uses n+1 cells; last carry lands in an extra cell.
// [RQ13] Cascade combines adjacent cell results by AND, or OR via inversion.
// [RQ14] Each cascaded cell adds four inputs; n cells give 4n inputs.
// [RQ15] Cascade past eight cells continues two clusters along, parity kept.
// [RQ16] Cascade chain stops at row centre; new chain starts in next cluster.
// [RQ17] Four cell modes: normal, arithmetic, up/down counter, clearable counter.
// [RQ18] Seven cell inputs: four data, register feedback, carry-in, cascade-in.
// [RQ19] Three separate inputs give register clock, clear and preset.
// [RQ20] Synchronous clock enable in all modes; data input one may drive it.
// [RQ21] Arithmetic mode splits table into sum and carry halves of three inputs.
// [RQ22] Counter modes choose count or load data through a two-way selector.
// [RQ23] Clearable counter ANDs selector output with synchronous clear.
// [RQ24] Chip-wide reset beats every clear, preset and load of the register.
// [RQ25] Mode, routing, inversion and register type are static configuration bits.
// [RQ26] Register updates only on selected clock edge with enable high, else holds.
`define LCC_NUM_CELLS   8
`define LCC_NUM_LINES   4
`define LCC_NUM_CLKS    2
`define LCC_ADDR_W      8
`define LCC_DATA_W      32
`define LCC_OFS_CELL0   8'h00
`define LCC_OFS_CLU_CFG 8'h20
`define LCC_OFS_STATUS  8'h24
`define LCC_OFS_LINES   8'h28
`define LCC_CELL_RST    32'h0000_0000
`define LCC_CLU_RST     32'h0000_0000
`define LCC_SRC_DED     2'h0
`define LCC_SRC_GLOBAL  2'h1
`define LCC_SRC_IO      2'h2
`define LCC_SRC_LOCAL   2'h3
`define LCC_IDX_CLU     4'h8
`define LCC_IDX_STATUS  4'h9
`define LCC_IDX_LINES   4'hA
`define LCC_IDX_NONE    4'hF
`define LCC_ADDER_MASK  16'hE896
`endif

/* File: src/lcc_pkg.sv */
`include "lcc_defs.svh"
package lcc_pkg;
  typedef enum logic [1:0] {MODE_NORMAL, MODE_ARITH, MODE_UPDN, MODE_CLRCNT} lcc_mode_t;
  typedef enum logic [1:0] {FF_D, FF_T, FF_JK, FF_SR} lcc_ff_t;

  typedef struct packed {
    logic        rsv;
    logic        pack_d4;
    logic        carry_as_d3;
    logic        pre_en;
    logic        clr_sel;
    logic        clr_en;
    logic        clk_sel;
    logic        casc_or;
    logic        casc_en;
    logic        ce_from_d1;
    logic        row_sel_reg;
    logic        loc_sel_reg;
    lcc_ff_t     ff_type;
    lcc_mode_t   mode;
    logic [15:0] lut_mask;
  } lcc_cell_cfg_t;

  typedef struct packed {
    logic [17:0] rsv;
    logic        break_casc;
    logic        break_carry;
    logic [3:0][1:0] src_sel;
    logic [3:0]  inv;
  } lcc_clu_cfg_t;

  typedef struct packed {
    logic cell_data_in_four;
    logic cell_data_in_three;
    logic cell_data_in_two;
    logic cell_data_in_one;
  } lcc_cell_data_t;

  typedef struct packed {
    logic [1:0] ded_clk;
    logic [3:0] global_sig;
    logic [3:0] io_sig;
    logic [3:0] local_sig;
  } lcc_ctrl_src_t;
endpackage

/* File: testbench/lcc_cluster_tb_top.sv */
`timescale 1ns/1ns
`include "lcc_defs.svh"
module lcc_cluster_tb_top;
  typedef struct {int at; int sel; logic [31:0] msk; logic [31:0] exp;} lcc_note_t;
  logic                          I_SYS_CLK = 1'b0;
  logic                          I_RSTN, I_CE, I_WE, I_RE, I_CHIP_RSTN;
  logic [7:0]                    I_ADDR;
  logic [31:0]                   I_WDATA, O_RDATA, seen, rw;
  lcc_pkg::lcc_cell_data_t [7:0] I_CELL_DATA, dat;
  lcc_pkg::lcc_ctrl_src_t        ctrl_src, src;
  logic                          carry_in, cascade_in, O_CARRY_OUT, O_CASCADE_OUT, ci, ex;
  logic [7:0]                    O_LOCAL_OUT, O_ROW_OUT, a, b, lut;
  logic [8:0]                    sum;
  lcc_note_t                     notes[$];
  lcc_note_t                     nt;
  int                            cyc = 0, wd = 0, num_errors = 0, checks_done = 0;
  lcc_pkg::lcc_cell_cfg_t        cfg;
  lcc_pkg::lcc_clu_cfg_t         cc;
  string                         what[4] = '{"read data", "local out", "row out", "chain out"};

  always #5 I_SYS_CLK = ~I_SYS_CLK;

  lcc_nbr_model lcc_nbr_model_i (.i_clk(I_SYS_CLK), .o_src(ctrl_src), .o_carry(carry_in), .o_cascade(cascade_in));
  lcc_cluster lcc_cluster_i (
    .I_SYS_CLK(I_SYS_CLK), .I_RSTN(I_RSTN), .I_CE(I_CE), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WE(I_WE),
    .I_RE(I_RE), .O_RDATA(O_RDATA), .I_CTRL_SRC(ctrl_src), .I_CHIP_RSTN(I_CHIP_RSTN), .I_CELL_DATA(I_CELL_DATA),
    .I_CARRY_IN(carry_in), .I_CASCADE_IN(cascade_in), .O_CARRY_OUT(O_CARRY_OUT), .O_CASCADE_OUT(O_CASCADE_OUT),
    .O_LOCAL_OUT(O_LOCAL_OUT), .O_ROW_OUT(O_ROW_OUT));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input int sel, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what[sel], e, s);
    end
  endtask
  // Result due one edge after the inputs land
  task automatic note(input int sel, input logic [31:0] msk, input logic [31:0] e);
    notes.push_back('{cyc + 2, sel, msk, e & msk});
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge I_SYS_CLK);
    I_WE    <= 1'b1;
    I_ADDR  <= ad;
    I_WDATA <= d;
    @(posedge I_SYS_CLK);
    I_WE    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] msk, input logic [31:0] e);
    @(posedge I_SYS_CLK);
    I_RE   <= 1'b1;
    I_ADDR <= ad;
    note(0, msk, e);
    @(posedge I_SYS_CLK);
    I_RE   <= 1'b0;
  endtask
  task automatic wr_all(input logic [31:0] d);
    for (int i = 0; i < 8; i++) wr(8'(4 * i), d);
  endtask
  task automatic reg_chk(input logic v);
    repeat (3) @(posedge I_SYS_CLK);
    note(1, 32'h0000_0001, {31'h0, v});
    rd(`LCC_OFS_STATUS, 32'h0000_0001, {31'h0, v});
  endtask
  task automatic pulse();
    lcc_nbr_model_i.set_line(0, 1'b1);
    lcc_nbr_model_i.set_line(0, 1'b0);
  endtask
  function automatic logic [3:0] line_val(input lcc_pkg::lcc_ctrl_src_t s, input logic [1:0] k, input logic [3:0] inv);
    logic [3:0] v;
    case (k)
      2'h0: v = {s.local_sig[3:2], s.ded_clk};
      2'h1: v = s.global_sig;
      2'h2: v = s.io_sig;
      default: v = s.local_sig;
    endcase
    return v ^ inv;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge I_SYS_CLK) begin
    #1;
    cyc++;
    while (notes.size() > 0 && notes[0].at <= cyc) begin
      nt = notes.pop_front();
      case (nt.sel)
        0: seen = O_RDATA;
        1: seen = {24'h0, O_LOCAL_OUT};
        2: seen = {24'h0, O_ROW_OUT};
        default: seen = {30'h0, O_CASCADE_OUT, O_CARRY_OUT};
      endcase
      chk(nt.sel, seen & nt.msk, nt.exp);
    end
  end
  always @(posedge I_SYS_CLK) begin
    wd++;
    if (wd == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {I_RSTN, I_WE, I_RE, I_ADDR, I_WDATA, I_CELL_DATA} = '0;
    {I_CE, I_CHIP_RSTN} = 2'b11;
    void'($urandom(50924));
    repeat (20) @(posedge I_SYS_CLK);
    I_RSTN <= 1'b1;
    repeat (4) @(posedge I_SYS_CLK);
    // Reset values, read-only places, unmapped and unaligned accesses
    rd(`LCC_OFS_CELL0, '1, `LCC_CELL_RST);
    rd(`LCC_OFS_CLU_CFG, '1, `LCC_CLU_RST);
    rw = $urandom;
    wr(8'h1C, rw);
    wr(`LCC_OFS_LINES, '1);
    wr(8'h01, '1);
    rd(8'h1C, '1, rw);
    rd(`LCC_OFS_LINES, '1, 32'h0000_0000);
    rd(8'h00, '1, 32'h0000_0000);
    rd(8'h30, '1, 32'h0000_0000);
    // Every source kind on every line, with random inversion
    for (int k = 0; k < 4; k++) begin
      src = $urandom;
      cc = '0;
      cc.inv = $urandom;
      for (int l = 0; l < 4; l++) cc.src_sel[l] = 2'(k);
      wr(`LCC_OFS_CLU_CFG, cc);
      lcc_nbr_model_i.set_src(src);
      repeat (4) @(posedge I_SYS_CLK);
      rd(`LCC_OFS_LINES, 32'h0000_000F, {28'h0, line_val(src, 2'(k), cc.inv)});
    end
    // Full truth table of one cell, bypassing the register
    cfg = '0;
    cfg.lut_mask = $urandom;
    wr(8'h0C, cfg);
    for (int i = 0; i < 16; i++) begin
      @(posedge I_SYS_CLK);
      I_CELL_DATA[3] <= 4'(i);
      note(1, 32'h0000_0008, {28'h0, cfg.lut_mask[i], 3'h0});
    end
    // Eight-bit adder over the carry chain
    cfg = '0;
    cfg.mode = lcc_pkg::MODE_ARITH;
    cfg.lut_mask = `LCC_ADDER_MASK;
    wr_all(cfg);
    for (int t = 0; t < 24; t++) begin
      {a, b, ci} = $urandom;
      sum = a + b + 9'(ci);
      for (int i = 0; i < 8; i++) begin
        dat[i] = $urandom;
        dat[i].cell_data_in_two = a[i];
        dat[i].cell_data_in_three = b[i];
      end
      lcc_nbr_model_i.set_chain(ci, 1'b1);
      I_CELL_DATA <= dat;
      note(1, 32'h0000_00FF, {24'h0, sum[7:0]});
      note(3, 32'h0000_0001, {31'h0, sum[8]});
    end
    // Wide AND and OR over the cascade chain
    for (int m = 0; m < 2; m++) begin
      cfg = '0;
      cfg.lut_mask = 16'h8000;
      cfg.casc_en = 1'b1;
      cfg.casc_or = m[0];
      wr_all(cfg);
      for (int t = 0; t < 16; t++) begin
        ci = $urandom;
        dat = m ? 32'hF << (4 * ($urandom % 12)) : ~(32'h1 << ($urandom % 48));
        for (int i = 0; i < 8; i++) lut[i] = &dat[i];
        ex = m ? (ci | (|lut)) : (ci & (&lut));
        lcc_nbr_model_i.set_chain(1'b0, ci);
        I_CELL_DATA <= dat;
        note(3, 32'h0000_0002, {30'h0, ex, 1'b0});
      end
    end
    // Cell register on clock line zero from local routing
    cc = '0;
    cc.src_sel = '1;
    wr(`LCC_OFS_CLU_CFG, cc);
    lcc_nbr_model_i.set_src('0);
    cfg = '0;
    cfg.lut_mask = 16'hFF00;
    cfg.loc_sel_reg = 1'b1;
    wr(`LCC_OFS_CELL0, cfg);
    I_CELL_DATA <= {28'h0, 4'h8};
    reg_chk(1'b0);
    pulse();
    reg_chk(1'b1);
    I_CELL_DATA[0] <= 4'h0;
    note(2, 32'h0000_0001, 32'h0000_0000);
    reg_chk(1'b1);
    cfg.ce_from_d1 = 1'b1;
    wr(`LCC_OFS_CELL0, cfg);
    pulse();
    reg_chk(1'b1);
    I_CELL_DATA[0] <= 4'h1;
    pulse();
    reg_chk(1'b0);
    cfg.ce_from_d1 = 1'b0;
    cfg.ff_type = lcc_pkg::FF_T;
    wr(`LCC_OFS_CELL0, cfg);
    I_CELL_DATA[0] <= 4'h8;
    pulse();
    reg_chk(1'b1);
    pulse();
    reg_chk(1'b0);
    // Clear on line two, preset on line three, clear and chip reset above preset
    cfg = '0;
    cfg.loc_sel_reg = 1'b1;
    cfg.clr_en = 1'b1;
    cfg.pre_en = 1'b1;
    wr(`LCC_OFS_CELL0, cfg);
    lcc_nbr_model_i.set_line(3, 1'b1);
    reg_chk(1'b1);
    lcc_nbr_model_i.set_line(2, 1'b1);
    reg_chk(1'b0);
    lcc_nbr_model_i.set_line(2, 1'b0);
    reg_chk(1'b1);
    I_CHIP_RSTN <= 1'b0;
    reg_chk(1'b0);
    I_CHIP_RSTN <= 1'b1;
    reg_chk(1'b1);
    lcc_nbr_model_i.set_line(3, 1'b0);
    // Counter modes: sync clear, load, count, frozen clock enable
    cfg = '0;
    cfg.loc_sel_reg = 1'b1;
    cfg.row_sel_reg = 1'b1;
    cfg.mode = lcc_pkg::MODE_CLRCNT;
    wr(`LCC_OFS_CELL0, cfg);
    I_CELL_DATA <= {28'h0, 4'h4};
    pulse();
    reg_chk(1'b0);
    I_CELL_DATA <= {28'h0, 4'hA};
    pulse();
    reg_chk(1'b1);
    cfg.mode = lcc_pkg::MODE_UPDN;
    cfg.lut_mask = 16'h0033;
    wr(`LCC_OFS_CELL0, cfg);
    I_CELL_DATA <= '0;
    pulse();
    reg_chk(1'b0);
    pulse();
    reg_chk(1'b1);
    I_CE <= 1'b0;
    pulse();
    I_CE <= 1'b1;
    reg_chk(1'b1);
    repeat (4) @(posedge I_SYS_CLK);
    report_and_stop();
  end
endmodule // lcc_cluster_tb_top

/* File: testbench/lcc_nbr_model.sv */
`timescale 1ns/1ns
module lcc_nbr_model (
  input  wire logic             i_clk,
  output lcc_pkg::lcc_ctrl_src_t o_src,
  output logic                  o_carry,
  output logic                  o_cascade
);
  initial begin
    o_src     = '0;
    o_carry   = 1'b0;
    o_cascade = 1'b1;
  end
  // Chain ends of the same-parity cluster two places back
  task automatic set_chain(input logic c, input logic k);
    @(posedge i_clk);
    o_carry   <= c;
    o_cascade <= k;
  endtask
  task automatic set_src(input lcc_pkg::lcc_ctrl_src_t s);
    @(posedge i_clk);
    o_src <= s;
  endtask
  // Slow source: level held well past the sync stages
  task automatic set_line(input int n, input logic v);
    @(posedge i_clk);
    o_src.local_sig[n] <= v;
    repeat (6) @(posedge i_clk);
  endtask
endmodule // lcc_nbr_model
